// ===== shared/sst_pkg.sv
// Shared constants and types for the scan sequence timing block.
// Assumes a single master clock domain; long counts scale by top parameters.
package sst_pkg;

    // Controller states, one-hot
    typedef enum logic [2:0] {
        SST_STANDBY = 3'b001,
        SST_SCAN    = 3'b010,
        SST_BLOCKED = 3'b100
    } sst_state_t;

    localparam int CNT_W = 32;
    localparam int SYNC_STAGES = 3;

    // Default cycle units for fast and slow system clock settings
    localparam int FAST_UNIT_DEFAULT = 2000;
    localparam int SLOW_UNIT_DEFAULT = 200000;
    // Default channel to channel sampling gaps
    localparam int FAST_GAP_DEFAULT = 1000;
    localparam int SLOW_GAP_DEFAULT = 100000;

    // Cycles trimmed from each high duration
    localparam logic [31:0] HIGH_TRIM = 32'h0000_0005;

    // Base period and per-group high base, in units, by upper code bits
    localparam logic [11:0] PERIOD_MULT [8] = '{
        12'h010, 12'h028, 12'h050, 12'h0a0, 12'h190, 12'h320, 12'h640, 12'hfa0
    };
    localparam logic [11:0] HIGH_MULT [8] = '{
        12'h002, 12'h005, 12'h00a, 12'h014, 12'h032, 12'h064, 12'h0c8, 12'h1f4
    };

    // Period code and group selection that overflow the period
    function automatic logic comboInvalid(input logic [1:0] low, input logic [1:0] sg);
        comboInvalid = (low == 2'h1 && sg == 2'h3) ||
                       (low == 2'h2 && sg[1]) ||
                       (low == 2'h3 && sg != 2'h0);
    endfunction : comboInvalid

endpackage : sst_pkg

// ===== shared/sst_timing_if.sv
// Link between the scan controller and its sequence timing engine.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface sst_timing_if;
    logic enable;
    logic [31:0] periodLen;
    logic [31:0] highLen;
    logic seqStart;
    logic runLevel;

    modport engine (input enable, input periodLen, input highLen,
                    output seqStart, output runLevel);
    modport ctrl (output enable, output periodLen, output highLen,
                  input seqStart, input runLevel);
endinterface : sst_timing_if

// ===== core/sst_seq_engine.sv
// Scan sequence period and high-time counter.
// Assumes lengths are stable while enabled; they are latched at each start.
`timescale 1ns/1ps
module sst_seq_engine (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Controller side
    sst_timing_if.engine tif
);

    logic active_reg, active_next;
    logic [31:0] cnt_reg, cnt_next;
    logic [31:0] periodL_reg, periodL_next;
    logic [31:0] highL_reg, highL_next;
    logic startNow;

    always_comb begin
        active_next = active_reg;
        cnt_next = cnt_reg;
        periodL_next = periodL_reg;
        highL_next = highL_reg;
        startNow = 1'b0;
        if (!tif.enable) begin
            // Disabled: next sequence restarts from the top
            active_next = 1'b0;
            cnt_next = '0;
        end else if (!active_reg || cnt_reg == periodL_reg - 32'h1) begin
            active_next = 1'b1;
            cnt_next = '0;
            periodL_next = tif.periodLen;
            highL_next = tif.highLen;
            startNow = 1'b1;
        end else begin
            cnt_next = cnt_reg + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            active_reg <= 1'b0;
            cnt_reg <= '0;
            periodL_reg <= 32'h1;
            highL_reg <= '0;
        end else begin
            active_reg <= active_next;
            cnt_reg <= cnt_next;
            periodL_reg <= periodL_next;
            highL_reg <= highL_next;
        end
    end

    assign tif.seqStart = startNow;
    // High from start until the last channel's sample point
    // Start cycle is the first high cycle, so the count covers the remaining ones
    assign tif.runLevel = tif.enable && (startNow ? (tif.highLen != 32'h0)
                          : (active_reg && cnt_reg + 32'h1 < highL_reg));

    a_count_in_period: assert property (@(posedge mclk) disable iff (!resetn)
        active_reg |-> cnt_reg < periodL_reg)
        else $error("count ran past period");
    a_start_raises_run: assert property (@(posedge mclk) disable iff (!resetn)
        tif.seqStart && tif.highLen != 32'h0 |-> tif.runLevel)
        else $error("run not raised at start");
    a_run_falls_end: assert property (@(posedge mclk) disable iff (!resetn)
        active_reg && tif.enable && !tif.seqStart && highL_reg < periodL_reg
        && cnt_reg + 32'h2 == highL_reg |=> !tif.runLevel)
        else $error("run did not fall after high time");
    a_disable_restarts: assert property (@(posedge mclk) disable iff (!resetn)
        !tif.enable |=> !active_reg && cnt_reg == 32'h0)
        else $error("engine kept running while disabled");

endmodule : sst_seq_engine

// ===== core/sst_top.sv
// Scan sequence enable, timing decode and run indication.
// Assumes the command enable is a level from logic on mclk; the pin is async.
//
// Notes on behaviour
// - Sequences start only while enabled; disabling halts sampling and transmission.
// - Enable comes from the input pin and from a bus command; either suspends.
// - Enable level zero disables sequences, level one enables them.
// - Run indication rises at the start of every scan sequence.
// - Run indication falls when the last active channel is sampled.
// - Fast setting high time doubles with each group selection step.
// - Upper code bits pick base period; each low step halves it.
// - Upper code bits also pick the per-group high-time base.
// - Combinations whose sequence overflows the period are invalid and run nothing.
// - Channel sampling gap in master clocks depends on system clock select.
`timescale 1ns/1ps
module sst_top #(
    parameter int FAST_UNIT = sst_pkg::FAST_UNIT_DEFAULT,
    parameter int SLOW_UNIT = sst_pkg::SLOW_UNIT_DEFAULT,
    parameter int FAST_GAP = sst_pkg::FAST_GAP_DEFAULT,
    parameter int SLOW_GAP = sst_pkg::SLOW_GAP_DEFAULT
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Enable sources
    input wire logic scanEnableIn,
    input wire logic canScanEnable,
    // Configuration
    input wire logic [4:0] scanPeriodCode,
    input wire logic [1:0] channelGroupSelect,
    input wire logic systemClockSelect,
    // Status and indication
    output logic scanRunningOut,
    output logic sampleStrobeOut,
    output logic acquireEnableOut,
    output logic standbyOut,
    output logic configInvalidOut
);

    sst_timing_if tif ();

    sst_seq_engine u_engine (
        .mclk(mclk),
        .resetn(resetn),
        .tif(tif)
    );

    // Pin synchroniser; a change counts once stages two and three agree
    logic [sst_pkg::SYNC_STAGES-1:0] pinSync_reg, pinSync_next;
    logic pinEnable_reg, pinEnable_next;

    always_comb begin
        pinSync_next = {pinSync_reg[sst_pkg::SYNC_STAGES-2:0], scanEnableIn};
        pinEnable_next = pinEnable_reg;
        if (pinSync_reg[1] == pinSync_reg[2]) begin
            pinEnable_next = pinSync_reg[2];
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            pinSync_reg <= '0;
            pinEnable_reg <= 1'b0;
        end else begin
            pinSync_reg <= pinSync_next;
            pinEnable_reg <= pinEnable_next;
        end
    end

    // Timing decode
    logic enableReq;
    logic cfgInvalid;
    logic [31:0] unitCycles;
    logic [31:0] periodLen;
    logic [31:0] highLen;
    logic [31:0] gapLen;

    always_comb begin
        enableReq = pinEnable_reg && canScanEnable;
        cfgInvalid = sst_pkg::comboInvalid(scanPeriodCode[1:0], channelGroupSelect);
        unitCycles = systemClockSelect ? 32'(FAST_UNIT) : 32'(SLOW_UNIT);
        gapLen = systemClockSelect ? 32'(FAST_GAP) : 32'(SLOW_GAP);
        periodLen = 32'(32'(sst_pkg::PERIOD_MULT[scanPeriodCode[4:2]]) * unitCycles)
                    >> scanPeriodCode[1:0];
        highLen = (32'(32'(sst_pkg::HIGH_MULT[scanPeriodCode[4:2]]) * unitCycles)
                  << channelGroupSelect) - sst_pkg::HIGH_TRIM;
    end

    // Controller state
    sst_pkg::sst_state_t state_reg, state_next;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sst_pkg::SST_STANDBY: begin
                if (enableReq) begin
                    state_next = cfgInvalid ? sst_pkg::SST_BLOCKED : sst_pkg::SST_SCAN;
                end
            end
            sst_pkg::SST_SCAN: begin
                if (!enableReq) begin
                    state_next = sst_pkg::SST_STANDBY;
                end else if (cfgInvalid) begin
                    state_next = sst_pkg::SST_BLOCKED;
                end
            end
            sst_pkg::SST_BLOCKED: begin
                if (!enableReq) begin
                    state_next = sst_pkg::SST_STANDBY;
                end else if (!cfgInvalid) begin
                    state_next = sst_pkg::SST_SCAN;
                end
            end
            default: state_next = sst_pkg::SST_STANDBY;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_reg <= sst_pkg::SST_STANDBY;
        end else begin
            state_reg <= state_next;
        end
    end

    assign tif.enable = (state_reg == sst_pkg::SST_SCAN);
    assign tif.periodLen = periodLen;
    assign tif.highLen = highLen;

    // Channel sampling strobe and outputs
    logic [31:0] gapCnt_reg, gapCnt_next;
    logic running_reg, running_next;
    logic strobe_reg, strobe_next;
    logic acquire_reg, acquire_next;
    logic standby_reg, standby_next;
    logic invalid_reg, invalid_next;

    always_comb begin
        gapCnt_next = gapCnt_reg;
        strobe_next = 1'b0;
        running_next = tif.runLevel;
        acquire_next = tif.enable;
        standby_next = (state_reg == sst_pkg::SST_STANDBY);
        invalid_next = cfgInvalid;
        if (tif.seqStart) begin
            gapCnt_next = '0;
            strobe_next = tif.runLevel;
        end else if (tif.runLevel) begin
            if (gapCnt_reg >= gapLen - 32'h1) begin
                gapCnt_next = '0;
                strobe_next = 1'b1;
            end else begin
                gapCnt_next = gapCnt_reg + 32'h1;
            end
        end else begin
            gapCnt_next = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            gapCnt_reg <= '0;
            running_reg <= 1'b0;
            strobe_reg <= 1'b0;
            acquire_reg <= 1'b0;
            standby_reg <= 1'b1;
            invalid_reg <= 1'b0;
        end else begin
            gapCnt_reg <= gapCnt_next;
            running_reg <= running_next;
            strobe_reg <= strobe_next;
            acquire_reg <= acquire_next;
            standby_reg <= standby_next;
            invalid_reg <= invalid_next;
        end
    end

    assign scanRunningOut = running_reg;
    assign sampleStrobeOut = strobe_reg;
    assign acquireEnableOut = acquire_reg;
    assign standbyOut = standby_reg;
    assign configInvalidOut = invalid_reg;

    a_standby_no_run: assert property (@(posedge mclk) disable iff (!resetn)
        state_reg != sst_pkg::SST_SCAN |=> !scanRunningOut && !acquireEnableOut)
        else $error("run indication high outside scan state");
    a_enable_decode: assert property (@(posedge mclk) disable iff (!resetn)
        !pinEnable_reg || !canScanEnable |=> state_reg == sst_pkg::SST_STANDBY)
        else $error("disabled level did not stop sequences");
    a_invalid_blocks: assert property (@(posedge mclk) disable iff (!resetn)
        cfgInvalid |=> state_reg != sst_pkg::SST_SCAN)
        else $error("invalid combination allowed to scan");
    a_fast_high_four: assert property (@(posedge mclk) disable iff (!resetn)
        systemClockSelect && scanPeriodCode == 5'h00 && channelGroupSelect == 2'h3
        |-> highLen == 32'(FAST_UNIT) * 32'h10 - 32'h5)
        else $error("fast high time wrong for four groups");
    a_fast_period_step: assert property (@(posedge mclk) disable iff (!resetn)
        systemClockSelect && scanPeriodCode == 5'h03 |-> periodLen == 32'(FAST_UNIT) * 32'h2)
        else $error("fast period halving wrong");
    a_fast_high_base: assert property (@(posedge mclk) disable iff (!resetn)
        systemClockSelect && scanPeriodCode[4:2] == 3'h7 && channelGroupSelect == 2'h0
        |-> highLen == 32'(FAST_UNIT) * 32'h1f4 - 32'h5)
        else $error("top high base wrong");
    a_strobe_in_run: assert property (@(posedge mclk) disable iff (!resetn)
        sampleStrobeOut |-> scanRunningOut)
        else $error("sample strobe outside running sequence");
    a_run_edge_start: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(scanRunningOut) |-> $past(tif.seqStart))
        else $error("run rose without a sequence start");

    c_sequence_start: cover property (@(posedge mclk) disable iff (!resetn)
        $rose(scanRunningOut));
    c_sequence_end: cover property (@(posedge mclk) disable iff (!resetn)
        $fell(scanRunningOut) && acquireEnableOut);
    c_blocked: cover property (@(posedge mclk) disable iff (!resetn)
        state_reg == sst_pkg::SST_BLOCKED);
    c_disable_mid_run: cover property (@(posedge mclk) disable iff (!resetn)
        scanRunningOut ##1 standbyOut);

endmodule : sst_top

// ===== sim/sst_host_model.sv
// Host stand-in: drives the enable pin and the command enable toward the block.
// Assumes the bench issues its requests on the master clock.
`timescale 1ns/1ps
module sst_host_model (
    // Clock
    input wire logic mclk,
    // Requests from the bench
    input wire logic wantPin,
    input wire logic wantCmd,
    // Enable sources toward the device
    output logic scanEnableIn = 1'b0,
    output logic canScanEnable = 1'b0
);
    // Level one enables, level zero suspends; either source may suspend
    always @(posedge mclk) begin
        scanEnableIn <= wantPin;
        canScanEnable <= wantCmd;
    end
endmodule : sst_host_model

// ===== sim/tb.sv
// Self-checking bench for the scan sequence timing block.
// Assumes shortened units: fast 20, slow 40, gaps 4 and 8 clocks.
`timescale 1ns/1ps
module tb;
    localparam int UNIT = 20;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic wantPin = 1'b0;
    logic wantCmd = 1'b0;
    logic [4:0] code = 5'h00;
    logic [1:0] grp = 2'h0;
    logic fastSel = 1'b1;
    logic scanEnableIn, canScanEnable, running, strobe, acquire, standby, invalid;
    int mismatches = 0;
    int nChecks = 0;

    always #50 mclk = ~mclk;

    sst_host_model i_sst_host_model (.mclk(mclk), .wantPin(wantPin), .wantCmd(wantCmd),
        .scanEnableIn(scanEnableIn), .canScanEnable(canScanEnable));
    sst_top #(.FAST_UNIT(UNIT), .SLOW_UNIT(40), .FAST_GAP(4), .SLOW_GAP(8)) i_sst_top (
        .mclk(mclk), .resetn(resetn), .scanEnableIn(scanEnableIn),
        .canScanEnable(canScanEnable), .scanPeriodCode(code), .channelGroupSelect(grp),
        .systemClockSelect(fastSel), .scanRunningOut(running), .sampleStrobeOut(strobe),
        .acquireEnableOut(acquire), .standbyOut(standby), .configInvalidOut(invalid));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %0d want %0d", $time, what, got, exp);
        end
    endtask : check

    task automatic tick();
        @(posedge mclk);
        #1;
    endtask : tick

    task automatic apply(input logic p, input logic c, input logic [4:0] pc,
                         input logic [1:0] g, input logic f);
        @(posedge mclk);
        wantPin <= p;
        wantCmd <= c;
        code <= pc;
        grp <= g;
        fastSel <= f;
        #1;
    endtask : apply

    // Counts cycles until the run indication reaches a level
    task automatic waitRun(input logic lvl, input int limit, output int n);
        n = 0;
        while (running !== lvl) begin
            tick();
            n++;
            if (n > limit) begin
                mismatches++;
                $display("wrong value at %0t: run indication wait expired", $time);
                wrap_up();
            end
        end
    endtask : waitRun

    task automatic restart(input logic [4:0] c, input logic [1:0] g, input logic f);
        int n;
        apply(1'b1, 1'b0, code, grp, fastSel);
        waitRun(1'b0, 8, n);
        apply(1'b1, 1'b0, c, g, f);
        apply(1'b1, 1'b1, c, g, f);
    endtask : restart

    task automatic timing(input logic [4:0] c, input logic [1:0] g, input int eHigh,
                          input int ePer);
        int nHigh, nLow;
        restart(c, g, 1'b1);
        waitRun(1'b1, 8, nLow);
        check(invalid, 1'b0, "invalid flag");
        waitRun(1'b0, 2000, nHigh);
        waitRun(1'b1, 2000, nLow);
        check(nHigh, eHigh, "high time");
        check(nHigh + nLow, ePer, "period");
    endtask : timing

    task automatic refusals();
        logic [3:0] bad [6] = '{4'h7, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
        logic seen;
        foreach (bad[i]) begin
            restart({3'h0, bad[i][3:2]}, bad[i][1:0], 1'b1);
            seen = 1'b0;
            repeat (10) begin
                tick();
                seen = seen | running | acquire;
            end
            check(seen, 1'b0, "run on invalid");
            check(invalid, 1'b1, "invalid flag");
        end
    endtask : refusals

    task automatic suspend();
        int n;
        logic seen;
        timing(5'h00, 2'h3, 315, 320);
        repeat (10) tick();
        apply(1'b1, 1'b0, code, grp, fastSel);
        waitRun(1'b0, 3, n);
        check(acquire, 1'b0, "acquire on cmd off");
        check(standby, 1'b1, "standby on cmd off");
        seen = 1'b0;
        repeat (30) begin
            tick();
            seen = seen | running;
        end
        check(seen, 1'b0, "run while disabled");
        apply(1'b1, 1'b1, code, grp, fastSel);
        waitRun(1'b1, 3, n);
        waitRun(1'b0, 400, n);
        check(n, 315, "high after re-enable");
        apply(1'b0, 1'b1, code, grp, fastSel);
        waitRun(1'b0, 400, n);
        repeat (8) tick();
        check(standby, 1'b1, "standby on pin off");
        apply(1'b1, 1'b1, code, grp, fastSel);
        waitRun(1'b1, 8, n);
    endtask : suspend

    task automatic gaps(input logic f);
        int n;
        restart(5'h00, 2'h0, f);
        n = 0;
        while (strobe !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        check(strobe, 1'b1, "first strobe");
        n = 0;
        do begin
            tick();
            n++;
        end while (strobe !== 1'b1 && n < 20);
        check(n, f ? 4 : 8, "sample gap");
    endtask : gaps

    initial begin
        int basePer [3] = '{32000, 80000, 160000};
        int baseHigh [3] = '{4000, 10000, 20000};
        logic [6:0] tc [8] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h06, 7'h0c, 7'h13, 7'h29};
        repeat (5) tick();
        check(standby, 1'b1, "standby in reset");
        check(running, 1'b0, "run in reset");
        @(posedge mclk);
        resetn <= 1'b1;
        wantPin <= 1'b1;
        foreach (tc[i]) begin
            timing(tc[i][6:2], tc[i][1:0],
                ((baseHigh[tc[i][6:4]] * UNIT / 2000) << tc[i][1:0]) - 5,
                (basePer[tc[i][6:4]] * UNIT / 2000) >> tc[i][3:2]);
        end
        refusals();
        suspend();
        gaps(1'b1);
        gaps(1'b0);
        wrap_up();
    end
endmodule : tb
